// ==== cmm_core_mem.v ====
// memory map, stack pointer, register banks and external data move control
`timescale 1ns/1ps
`include "cmm_defines.vh"
module cmm_core_mem #(
    parameter FLASH_KB = 62,
    parameter FLASH_WRITABLE_KB = 56
) (
    // clock and reset
    input wire CLOCK_I,
    input wire RST_N_I,
    // special function register port
    input wire SFR_WE_I,
    input wire SFR_RE_I,
    input wire [7:0] SFR_ADDR_I,
    input wire [7:0] SFR_WDATA_I,
    output reg [7:0] SFR_RDATA_O,
    // internal RAM address resolution
    input wire [7:0] RAM_ADDR_I,
    input wire RAM_INDIRECT_I,
    input wire [2:0] REG_NUM_I,
    input wire [6:0] BIT_ADDR_I,
    output wire RAM_IS_SFR_O,
    output wire [7:0] REG_ADDR_O,
    output wire [7:0] BIT_BYTE_ADDR_O,
    output wire [2:0] BIT_POS_O,
    // stack operations
    input wire PUSH_I,
    input wire POP_I,
    output wire [10:0] STACK_ADDR_O,
    output wire STACK_IN_EXTENDED_DATA_RAM_O,
    // instruction timing
    input wire INSTR_START_I,
    input wire [2:0] INSTR_CLASS_I,
    input wire IRQ_CALL_I,
    output wire INSTR_DONE_O,
    output reg [3:0] INSTR_CYCLES_O,
    // external data move request
    input wire EXTERNAL_DATA_MOVE_START_I,
    input wire EXTERNAL_DATA_MOVE_WRITE_I,
    input wire [23:0] DATA_POINTER_I,
    input wire [7:0] EXTERNAL_DATA_MOVE_WDATA_I,
    output wire EXTERNAL_DATA_MOVE_BUSY_O,
    output reg [7:0] EXTERNAL_DATA_MOVE_RDATA_O,
    // port pins
    input wire [7:0] PORT_ZERO_I,
    output reg [7:0] PORT_ZERO_O,
    output reg PORT_ZERO_OE_O,
    output reg [7:0] PORT_TWO_O,
    output reg PORT_TWO_OE_O,
    output reg ADDR_LATCH_O,
    output reg RD_N_O,
    output reg WR_N_O,
    // code space
    input wire CODE_SOURCE_SELECT_PIN_I,
    input wire [15:0] FLASH_ADDR_I,
    output reg CODE_INTERNAL_O,
    output wire FLASH_WRITE_ALLOWED_O
);

    ////////////////////////////////////////////////////////////////////////
    // registers
    reg [7:0] stack_pointer_low;
    reg [2:0] stack_pointer_high;
    reg [2:0] external_data_move_wait_states;
    reg ext_stack_enable;
    reg internal_xdata_map_enable;
    reg [1:0] bank_select;
    reg strap_seen;
    reg [10:0] next_sp;

    wire wr_sp = SFR_WE_I && (SFR_ADDR_I == `CMM_ADDR_SP_LOW);
    wire wr_sph = SFR_WE_I && (SFR_ADDR_I == `CMM_ADDR_SP_HIGH);
    wire [10:0] sp_full = {stack_pointer_high, stack_pointer_low};

    // next stack pointer: pre-increment on push, post-decrement on pop
    always @*
    begin
        next_sp = sp_full;
        if (PUSH_I)
            next_sp = sp_full + 11'h001;
        else if (POP_I)
            next_sp = sp_full - 11'h001;
        if (!ext_stack_enable)
            next_sp[10:8] = 3'h0;
    end

    // extended stack carries into the upper bits, plain stack wraps in 8 bits
    always @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            stack_pointer_low <= `CMM_SP_RESET;
            stack_pointer_high <= 3'h0;
        end
        else
        begin
            if (PUSH_I || POP_I)
            begin
                stack_pointer_low <= next_sp[7:0];
                stack_pointer_high <= next_sp[10:8];
            end
            if (wr_sp)
                stack_pointer_low <= SFR_WDATA_I;
            if (wr_sph && ext_stack_enable)
                stack_pointer_high <= SFR_WDATA_I[2:0];
            else if (!ext_stack_enable)
                stack_pointer_high <= 3'h0;
        end
    end

    // configuration, wait states and bank select
    always @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            external_data_move_wait_states <= 3'h0;
            ext_stack_enable <= 1'b0;
            internal_xdata_map_enable <= 1'b0;
            bank_select <= `CMM_BANK_RESET;
        end
        else if (SFR_WE_I)
        begin
            if (SFR_ADDR_I == `CMM_ADDR_WAIT)
                external_data_move_wait_states <= SFR_WDATA_I[2:0];
            if (SFR_ADDR_I == `CMM_ADDR_CONFIG)
            begin
                ext_stack_enable <= SFR_WDATA_I[`CMM_CFG_EXT_STACK_BIT];
                internal_xdata_map_enable <= SFR_WDATA_I[`CMM_CFG_MAP_BIT];
            end
            if (SFR_ADDR_I == `CMM_ADDR_BANK)
                bank_select <= SFR_WDATA_I[`CMM_BANK_LSB+1:`CMM_BANK_LSB];
        end
    end

    // register read back; unmapped addresses and hidden high byte read zero
    always @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            SFR_RDATA_O <= 8'h00;
        else if (SFR_RE_I)
        begin
            case (SFR_ADDR_I)
                `CMM_ADDR_SP_LOW: SFR_RDATA_O <= stack_pointer_low;
                `CMM_ADDR_WAIT: SFR_RDATA_O <= {5'h00, external_data_move_wait_states};
                `CMM_ADDR_CONFIG: SFR_RDATA_O <= {ext_stack_enable, 6'h00,
                    internal_xdata_map_enable};
                `CMM_ADDR_SP_HIGH: SFR_RDATA_O <= ext_stack_enable ?
                    {5'h00, stack_pointer_high} : 8'h00;
                `CMM_ADDR_BANK: SFR_RDATA_O <= {3'h0, bank_select, 3'h0};
                default: SFR_RDATA_O <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // internal RAM addressing
    assign RAM_IS_SFR_O = RAM_ADDR_I[7] && !RAM_INDIRECT_I;
    assign REG_ADDR_O = {3'h0, bank_select, REG_NUM_I};
    assign BIT_BYTE_ADDR_O = 8'h20 + {4'h0, BIT_ADDR_I[6:3]};
    assign BIT_POS_O = BIT_ADDR_I[2:0];
    assign STACK_ADDR_O = sp_full;
    assign STACK_IN_EXTENDED_DATA_RAM_O = ext_stack_enable && (sp_full[10:8] != 3'h0);

    ////////////////////////////////////////////////////////////////////////
    // instruction cycle counting
    reg [3:0] instr_count;
    reg [3:0] instr_len;

    // cycle length per instruction class
    always @*
    begin
        case (INSTR_CLASS_I)
            `CMM_OP_NOP: instr_len = {1'b0, `CMM_CYC_SINGLE};
            `CMM_OP_SHORT: instr_len = {1'b0, `CMM_CYC_SHORT_BRANCH};
            `CMM_OP_LONG: instr_len = {1'b0, `CMM_CYC_LONG_BRANCH};
            `CMM_OP_CALL: instr_len = IRQ_CALL_I ? {1'b0, `CMM_CYC_IRQ_CALL} :
                {1'b0, `CMM_CYC_LONG_BRANCH};
            `CMM_OP_EXTERNAL_DATA_MOVE: instr_len = `CMM_CYC_EXTERNAL_DATA_MOVE_BASE + {1'b0, external_data_move_wait_states};
            default: instr_len = {1'b0, `CMM_CYC_SINGLE};
        endcase
    end

    // count down; done pulses in the last cycle
    always @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            instr_count <= 4'h0;
            INSTR_CYCLES_O <= 4'h0;
        end
        else if (INSTR_START_I && instr_count <= 4'h1)
        begin
            instr_count <= instr_len;
            INSTR_CYCLES_O <= instr_len;
        end
        else if (instr_count != 4'h0)
            instr_count <= instr_count - 4'h1;
    end
    assign INSTR_DONE_O = (instr_count == 4'h1);

    ////////////////////////////////////////////////////////////////////////
    // external data move sequencer
    localparam ST_IDLE = 2'h0;
    localparam ST_ADDR = 2'h1;
    localparam ST_STROBE = 2'h2;
    localparam ST_END = 2'h3;

    reg [1:0] state;
    reg [2:0] wait_left;
    reg is_internal;
    reg is_write;
    reg [10:0] extended_data_ram_addr;
    reg [7:0] wdata;
    wire extended_data_ram_we;
    wire [7:0] extended_data_ram_rdata;
    wire [10:0] extended_data_ram_port_addr;
    wire hit_internal = internal_xdata_map_enable && (DATA_POINTER_I <= `CMM_EXTENDED_DATA_RAM_TOP);

    // pushes while the stack is above FF steer the port address to next_sp (no write is made); move accesses otherwise
    assign extended_data_ram_port_addr = (PUSH_I && STACK_IN_EXTENDED_DATA_RAM_O) ? next_sp : extended_data_ram_addr;
    assign extended_data_ram_we = (state == ST_STROBE && is_internal && is_write && wait_left == 3'h0);

    cmm_ram #(
        .AW(11),
        .DW(8)
    ) u_extended_data_ram (
        .clk_i(CLOCK_I),
        .we_i(extended_data_ram_we),
        .addr_i(extended_data_ram_port_addr),
        .wdata_i(wdata),
        .rdata_o(extended_data_ram_rdata)
    );

    // address cycle, strobe held for 1+n cycles, closing cycle: 4+n total
    always @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            state <= ST_IDLE;
            wait_left <= 3'h0;
            is_internal <= 1'b0;
            is_write <= 1'b0;
            extended_data_ram_addr <= 11'h000;
            wdata <= 8'h00;
            EXTERNAL_DATA_MOVE_RDATA_O <= 8'h00;
            PORT_ZERO_O <= 8'h00;
            PORT_ZERO_OE_O <= 1'b0;
            PORT_TWO_O <= 8'h00;
            PORT_TWO_OE_O <= 1'b0;
            ADDR_LATCH_O <= 1'b0;
            RD_N_O <= 1'b1;
            WR_N_O <= 1'b1;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (EXTERNAL_DATA_MOVE_START_I)
                    begin
                        state <= ST_ADDR;
                        is_internal <= hit_internal;
                        is_write <= EXTERNAL_DATA_MOVE_WRITE_I;
                        extended_data_ram_addr <= DATA_POINTER_I[10:0];
                        wdata <= EXTERNAL_DATA_MOVE_WDATA_I;
                        wait_left <= external_data_move_wait_states;
                        if (!hit_internal)
                        begin
                            // low byte on port zero, high on port two
                            PORT_ZERO_O <= DATA_POINTER_I[7:0];
                            PORT_ZERO_OE_O <= 1'b1;
                            PORT_TWO_O <= DATA_POINTER_I[15:8];
                            PORT_TWO_OE_O <= 1'b1;
                            ADDR_LATCH_O <= 1'b1;
                        end
                    end
                end
                ST_ADDR:
                begin
                    state <= ST_STROBE;
                    ADDR_LATCH_O <= 1'b0;
                    if (!is_internal)
                    begin
                        // internal hits never touch the pins
                        PORT_ZERO_O <= wdata;
                        PORT_ZERO_OE_O <= is_write;
                        RD_N_O <= is_write;
                        WR_N_O <= !is_write;
                    end
                end
                ST_STROBE:
                begin
                    if (wait_left != 3'h0)
                        wait_left <= wait_left - 3'h1;
                    else
                    begin
                        state <= ST_END;
                        if (!is_internal && !is_write)
                            EXTERNAL_DATA_MOVE_RDATA_O <= PORT_ZERO_I;
                        RD_N_O <= 1'b1;
                        WR_N_O <= 1'b1;
                        PORT_ZERO_OE_O <= 1'b0;
                        PORT_TWO_OE_O <= 1'b0;
                    end
                end
                ST_END:
                begin
                    state <= ST_IDLE;
                    if (is_internal && !is_write)
                        EXTERNAL_DATA_MOVE_RDATA_O <= extended_data_ram_rdata;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
    assign EXTERNAL_DATA_MOVE_BUSY_O = (state != ST_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // code space: internal or external as set by the strap pin, caught once after reset release
    always @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            strap_seen <= 1'b0;
            CODE_INTERNAL_O <= 1'b0;
        end
        else if (!strap_seen)
        begin
            strap_seen <= 1'b1;
            CODE_INTERNAL_O <= CODE_SOURCE_SELECT_PIN_I;
        end
    end

    // flash above the writable area is protected at runtime
    assign FLASH_WRITE_ALLOWED_O = ({16'h0000, FLASH_ADDR_I} <
        FLASH_WRITABLE_KB * 1024);
endmodule

// ==== cmm_core_mem_properties.sv ====
// assertion checker for the memory map and data move block
`timescale 1ns/1ps
`include "cmm_defines.vh"
module cmm_core_mem_properties (
    // clock and reset
    input wire CLOCK_I,
    input wire RST_N_I,
    // register port and address resolution
    input wire SFR_WE_I,
    input wire [7:0] SFR_ADDR_I,
    input wire [7:0] SFR_WDATA_I,
    input wire [7:0] RAM_ADDR_I,
    input wire RAM_INDIRECT_I,
    input wire RAM_IS_SFR_O,
    input wire [6:0] BIT_ADDR_I,
    input wire [7:0] BIT_BYTE_ADDR_O,
    input wire [2:0] BIT_POS_O,
    // timing and data move
    input wire INSTR_START_I,
    input wire [2:0] INSTR_CLASS_I,
    input wire IRQ_CALL_I,
    input wire INSTR_DONE_O,
    input wire EXTERNAL_DATA_MOVE_BUSY_O,
    input wire RD_N_O,
    input wire WR_N_O
);
    default clocking dc @(posedge CLOCK_I);
    endclocking
    default disable iff (!RST_N_I);
    reg [2:0] wait_q;
    reg [3:0] busy_cnt;
    ////////////////////////////////////////////////////////////////////////
    // shadow of the wait count; moves must not overlap a rewrite of it
    always @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            wait_q <= 3'h0;
            busy_cnt <= 4'h0;
        end
        else
        begin
            if (SFR_WE_I && SFR_ADDR_I == `CMM_ADDR_WAIT)
                wait_q <= SFR_WDATA_I[2:0];
            busy_cnt <= EXTERNAL_DATA_MOVE_BUSY_O ? busy_cnt + 4'h1 : 4'h0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // decode and timing relations
    sfr_decode_a: assert property (
        RAM_IS_SFR_O == (RAM_ADDR_I[7] && !RAM_INDIRECT_I)) else $error("sfr decode wrong");
    bit_area_a: assert property (
        BIT_BYTE_ADDR_O == 8'h20 + {4'h0, BIT_ADDR_I[6:3]} && BIT_POS_O == BIT_ADDR_I[2:0])
        else $error("bit address map wrong");
    nop_one_a: assert property (
        INSTR_START_I && INSTR_CLASS_I == `CMM_OP_NOP |=> INSTR_DONE_O) else $error("nop length");
    short_branch_a: assert property (
        INSTR_START_I && INSTR_CLASS_I == `CMM_OP_SHORT |=> !INSTR_DONE_O [*2] ##1 INSTR_DONE_O)
        else $error("short branch length");
    long_branch_a: assert property (
        INSTR_START_I && (INSTR_CLASS_I == `CMM_OP_LONG || INSTR_CLASS_I == `CMM_OP_CALL
        && !IRQ_CALL_I) |=> !INSTR_DONE_O [*3] ##1 INSTR_DONE_O) else $error("long length");
    irq_call_a: assert property (
        INSTR_START_I && INSTR_CLASS_I == `CMM_OP_CALL && IRQ_CALL_I
        |=> !INSTR_DONE_O ##1 !INSTR_DONE_O ##1 INSTR_DONE_O) else $error("irq call length");
    move_length_a: assert property (
        $fell(EXTERNAL_DATA_MOVE_BUSY_O) |-> busy_cnt + 4'h1 == `CMM_CYC_EXTERNAL_DATA_MOVE_BASE + {1'h0, wait_q})
        else $error("data move length");
    strobe_idle_a: assert property (
        !EXTERNAL_DATA_MOVE_BUSY_O |-> RD_N_O && WR_N_O) else $error("strobe outside a move");
endmodule

bind cmm_core_mem cmm_core_mem_properties i_cmm_core_mem_properties (.CLOCK_I, .RST_N_I,
    .SFR_WE_I, .SFR_ADDR_I, .SFR_WDATA_I, .RAM_ADDR_I, .RAM_INDIRECT_I, .RAM_IS_SFR_O,
    .BIT_ADDR_I, .BIT_BYTE_ADDR_O, .BIT_POS_O, .INSTR_START_I, .INSTR_CLASS_I, .IRQ_CALL_I,
    .INSTR_DONE_O, .EXTERNAL_DATA_MOVE_BUSY_O, .RD_N_O, .WR_N_O);

// ==== cmm_defines.vh ====
// constants for the core memory map, stack and external data move block
`ifndef CMM_DEFINES_VH
`define CMM_DEFINES_VH
`define CMM_ADDR_SP_LOW 8'h81
`define CMM_ADDR_WAIT 8'h9F
`define CMM_ADDR_CONFIG 8'hAF
`define CMM_ADDR_SP_HIGH 8'hB7
`define CMM_ADDR_BANK 8'hD0
`define CMM_SP_RESET 8'h07
`define CMM_WAIT_RESET 8'h00
`define CMM_CONFIG_RESET 8'h00
`define CMM_BANK_RESET 2'h0
`define CMM_CFG_EXT_STACK_BIT 7
`define CMM_CFG_MAP_BIT 0
`define CMM_BANK_LSB 3
`define CMM_EXTENDED_DATA_RAM_TOP 24'h0007FF
`define CMM_CYC_SHORT_BRANCH 3'h3
`define CMM_CYC_LONG_BRANCH 3'h4
`define CMM_CYC_IRQ_CALL 3'h3
`define CMM_CYC_SINGLE 3'h1
`define CMM_CYC_EXTERNAL_DATA_MOVE_BASE 4'h4
`define CMM_OP_NOP 3'h0
`define CMM_OP_SHORT 3'h1
`define CMM_OP_LONG 3'h2
`define CMM_OP_CALL 3'h3
`define CMM_OP_EXTERNAL_DATA_MOVE 3'h4
`endif

// ==== cmm_ram.v ====
// single-port memory with registered read data
`timescale 1ns/1ps
module cmm_ram #(
    parameter AW = 11,
    parameter DW = 8
) (
    input wire clk_i,
    input wire we_i,
    input wire [AW-1:0] addr_i,
    input wire [DW-1:0] wdata_i,
    output reg [DW-1:0] rdata_o
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // write first-less: read returns old contents
    always @(posedge clk_i)
    begin
        if (we_i)
            mem[addr_i] <= wdata_i;
        rdata_o <= mem[addr_i];
    end
endmodule

// ==== cmm_xmem.sv ====
// behavioural external data memory on the multiplexed port bus
`timescale 1ns/1ps
module cmm_xmem (
    // block side of the bus
    input wire clk_i,
    input wire [7:0] port_zero_i,
    input wire port_zero_oe_i,
    input wire [7:0] port_two_i,
    input wire latch_i,
    input wire rd_n_i,
    input wire wr_n_i,
    // resolved level on port zero
    output wire [7:0] bus_o
);
    reg [7:0] mem [0:1023];
    reg [15:0] addr = 16'h0000;
    reg [7:0] last = 8'h00;
    ////////////////////////////////////////////////////////////////////////
    // undriven bus toggles so stale data never passes for a read
    assign bus_o = port_zero_oe_i ? port_zero_i : !rd_n_i ? mem[addr[9:0]] : ~last;
    ////////////////////////////////////////////////////////////////////////
    // only ten address bits decoded, so higher addresses alias
    always @(posedge clk_i)
    begin
        if (latch_i)
            addr <= {port_two_i, port_zero_i};
        if (!wr_n_i)
            mem[addr[9:0]] <= port_zero_i;
        last <= bus_o;
    end
endmodule

// ==== tb_top.sv ====
// self-checking testbench for the memory map and data move block
`timescale 1ns/1ps
`include "cmm_defines.vh"
module tb_top;
    logic CLOCK_I, RST_N_I, SFR_WE_I, SFR_RE_I, RAM_INDIRECT_I, PUSH_I, POP_I, IRQ_CALL_I;
    logic INSTR_START_I, EXTERNAL_DATA_MOVE_START_I, EXTERNAL_DATA_MOVE_WRITE_I, CODE_SOURCE_SELECT_PIN_I;
    logic [7:0] SFR_ADDR_I, SFR_WDATA_I, RAM_ADDR_I, EXTERNAL_DATA_MOVE_WDATA_I, rd;
    logic [2:0] REG_NUM_I, INSTR_CLASS_I;
    logic [6:0] BIT_ADDR_I;
    logic [23:0] DATA_POINTER_I;
    logic [15:0] FLASH_ADDR_I;
    wire [7:0] SFR_RDATA_O, REG_ADDR_O, BIT_BYTE_ADDR_O, EXTERNAL_DATA_MOVE_RDATA_O, PORT_ZERO_O;
    wire [7:0] PORT_TWO_O, PORT_ZERO_I;
    wire [2:0] BIT_POS_O;
    wire [10:0] STACK_ADDR_O;
    wire [3:0] INSTR_CYCLES_O;
    wire RAM_IS_SFR_O, STACK_IN_EXTENDED_DATA_RAM_O, INSTR_DONE_O, EXTERNAL_DATA_MOVE_BUSY_O, PORT_ZERO_OE_O;
    wire PORT_TWO_OE_O, ADDR_LATCH_O, RD_N_O, WR_N_O, CODE_INTERNAL_O, FLASH_WRITE_ALLOWED_O;
    int num_errors = 0;
    int n_compared = 0;
    int n;
    logic strobed;
    cmm_core_mem i_cmm_core_mem (.*);
    cmm_xmem i_cmm_xmem (.clk_i(CLOCK_I), .port_zero_i(PORT_ZERO_O), .port_zero_oe_i(PORT_ZERO_OE_O),
        .port_two_i(PORT_TWO_O), .latch_i(ADDR_LATCH_O), .rd_n_i(RD_N_O), .wr_n_i(WR_N_O),
        .bus_o(PORT_ZERO_I));
    ////////////////////////////////////////////////////////////////////////
    // shared bus tasks and comparison
    task check(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge CLOCK_I);
        {SFR_WE_I, SFR_RE_I, SFR_ADDR_I, SFR_WDATA_I} = {w, !w, a, d};
        @(negedge CLOCK_I);
        {SFR_WE_I, SFR_RE_I} = 2'h0;
        rd = SFR_RDATA_O;
    endtask
    task stk(input logic up);
        @(negedge CLOCK_I);
        {PUSH_I, POP_I} = {up, !up};
        @(negedge CLOCK_I);
        {PUSH_I, POP_I} = 2'h0;
    endtask
    task instr(input logic [2:0] c, input logic q, input int len);
        @(negedge CLOCK_I);
        {INSTR_START_I, INSTR_CLASS_I, IRQ_CALL_I} = {1'h1, c, q};
        n = 0;
        #1;
        while (INSTR_DONE_O !== 1'h1 && n < 20)
        begin
            @(negedge CLOCK_I);
            INSTR_START_I = 1'h0;
            #1;
            n++;
        end
        @(negedge CLOCK_I);
        INSTR_START_I = 1'h0;
        check(n, len);
    endtask
    // strobed also notes port zero driven, which an internal hit must avoid
    task xmove(input logic [23:0] p, input logic w, input logic [7:0] d);
        @(negedge CLOCK_I);
        {EXTERNAL_DATA_MOVE_START_I, EXTERNAL_DATA_MOVE_WRITE_I, DATA_POINTER_I, EXTERNAL_DATA_MOVE_WDATA_I} = {1'h1, w, p, d};
        // the start cycle is the first of the 4+n
        n = 1;
        strobed = 1'h0;
        @(negedge CLOCK_I);
        EXTERNAL_DATA_MOVE_START_I = 1'h0;
        #1;
        while (EXTERNAL_DATA_MOVE_BUSY_O === 1'h1 && n < 20)
        begin
            n++;
            strobed |= RD_N_O !== 1'h1 || WR_N_O !== 1'h1 || PORT_ZERO_OE_O !== 1'h0;
            @(negedge CLOCK_I);
            #1;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task t_stack;
        sfr(1, 8'h81, 8'h07); stk(1); check(STACK_ADDR_O, 11'h008);
        sfr(1, 8'h81, 8'hFF); stk(1); check(STACK_ADDR_O, 11'h000);
        sfr(1, 8'hAF, 8'h80); sfr(1, 8'hB7, 8'h00); sfr(1, 8'h81, 8'hFF); stk(1);
        check({STACK_IN_EXTENDED_DATA_RAM_O, STACK_ADDR_O}, 12'h900);
        stk(0); check(STACK_ADDR_O, 11'h0FF);
        sfr(1, 8'hB7, 8'h05); sfr(0, 8'hB7, 8'h00); check(rd[2:0], 3'h5);
        sfr(1, 8'hAF, 8'h00); sfr(1, 8'hB7, 8'h02); sfr(0, 8'hB7, 8'h00); check(rd, 8'h00);
    endtask
    task t_regs;
        sfr(0, 8'h81, 8'h00); check(rd, 8'h07);
        sfr(0, 8'hAF, 8'h00); check(rd, 8'h00);
        sfr(1, 8'h9F, 8'hFF); sfr(0, 8'h9F, 8'h00); check(rd, 8'h07);
    endtask
    task t_timing;
        instr(`CMM_OP_NOP, 0, 1);
        instr(`CMM_OP_SHORT, 0, 3);
        instr(`CMM_OP_LONG, 0, 4);
        instr(`CMM_OP_CALL, 0, 4);
        instr(`CMM_OP_CALL, 1, 3);
        sfr(1, 8'h9F, 8'h00); instr(`CMM_OP_EXTERNAL_DATA_MOVE, 0, 4);
    endtask
    task t_move;
        sfr(1, 8'h9F, 8'h07); xmove(24'h001234, 1, 8'hA5);
        check({n[22:0], strobed}, 24'h017);
        xmove(24'h001234, 0, 8'h00); check(EXTERNAL_DATA_MOVE_RDATA_O, 8'hA5);
        sfr(1, 8'h9F, 8'h00); sfr(1, 8'hAF, 8'h01); xmove(24'h0007FF, 1, 8'h3C);
        check(strobed, 1'h0);
        xmove(24'h0007FF, 0, 8'h00); check({EXTERNAL_DATA_MOVE_RDATA_O, strobed}, 9'h078);
        xmove(24'h000800, 1, 8'h5A); check(strobed, 1'h1);
        xmove(24'h000800, 0, 8'h00); check(EXTERNAL_DATA_MOVE_RDATA_O, 8'h5A);
        sfr(1, 8'hAF, 8'h00); xmove(24'h0007FF, 0, 8'h00); check(strobed, 1'h1);
    endtask
    task t_map;
        for (int b = 0; b < 4; b++)
        begin
            sfr(1, 8'hD0, 8'(b << 3)); check(REG_ADDR_O, 8'(b * 8 + 5));
        end
        @(negedge CLOCK_I);
        {BIT_ADDR_I, RAM_ADDR_I, FLASH_ADDR_I} = {7'h7F, 8'h80, 16'hDFFF};
        #1 check({BIT_BYTE_ADDR_O, BIT_POS_O, RAM_IS_SFR_O}, 12'h2FF);
        check({CODE_INTERNAL_O, FLASH_WRITE_ALLOWED_O}, 2'h3);
        @(negedge CLOCK_I);
        {RAM_INDIRECT_I, FLASH_ADDR_I} = {1'h1, 16'hE000};
        #1 check({RAM_IS_SFR_O, FLASH_WRITE_ALLOWED_O}, 2'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // verdict, clock, watchdog and main sequence
    task stop_test;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        CLOCK_I = 1'h0;
        forever #4 CLOCK_I = ~CLOCK_I;
    end
    // the tests need well under ten thousand cycles
    initial
    begin
        #200000;
        num_errors++;
        stop_test;
    end
    initial
    begin
        {RST_N_I, SFR_WE_I, SFR_RE_I, RAM_INDIRECT_I, PUSH_I, POP_I, IRQ_CALL_I} = 7'h00;
        {INSTR_START_I, EXTERNAL_DATA_MOVE_START_I, EXTERNAL_DATA_MOVE_WRITE_I, REG_NUM_I, INSTR_CLASS_I} = 9'h028;
        {SFR_ADDR_I, SFR_WDATA_I, RAM_ADDR_I, EXTERNAL_DATA_MOVE_WDATA_I, BIT_ADDR_I} = 39'h0;
        {DATA_POINTER_I, FLASH_ADDR_I, CODE_SOURCE_SELECT_PIN_I} = 41'h1;
        repeat (3) @(posedge CLOCK_I);
        @(negedge CLOCK_I) RST_N_I = 1'h1;
        t_regs;
        t_stack;
        t_timing;
        t_move;
        t_map;
        stop_test;
    end
endmodule
